// ### core/pfr_pkg.sv
package pfr_pkg;

   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_FADDR  = 8'h04;
   localparam logic [7:0] OFF_ECODE  = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0C;
   localparam logic [7:0] OFF_DONE   = 8'h10;

   localparam int EC_PRESENT = 0;
   localparam int EC_WRITE   = 1;
   localparam int EC_USER    = 2;
   localparam int EC_RESERVED_VIOLATION_BIT    = 3;

   localparam int CTL_PAGING = 0;
   localparam int CTL_LARGE  = 1;
   localparam int CTL_EXT    = 2;
   localparam int CTL_WP     = 3;
   localparam logic [3:0] CTRL_RESET = 4'h0;

   localparam int ST_BUSY   = 0;
   localparam int ST_DOUBLE = 1;
   localparam int ST_TSLOAD = 2;
   localparam int ST_NEWCTX = 3;

   localparam int DONE_BIT = 0;

   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   typedef enum logic [2:0] {
      TS_NONE, TS_SAVE_OLD, TS_READ_GDT, TS_READ_TSS, TS_READ_SEG, TS_READ_LDT
   } pfr_ts_step_t;

   typedef enum {PF_IDLE, PF_TSLOAD, PF_PUSH, PF_DELIVER} pfr_state_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] linAddr;
      logic        isWrite;
      logic        userMode;
      logic        dirPresent;
      logic        tblPresent;
      logic        pageUser;
      logic        pageWritable;
      logic        rsvdSet;
   } pfr_xlat_t;

   typedef struct packed {
      logic hit;
      logic notPresent;
      logic protViol;
      logic rsvdViol;
   } pfr_fault_t;

   typedef struct packed {
      logic stackSplit;
      logic samePriv;
      logic sameTask;
   } pfr_stack_t;

endpackage : pfr_pkg

// ### core/pfr_fault_check.sv
`timescale 1ns/1ps
module pfr_fault_check (
   input  wire pfr_pkg::pfr_xlat_t  xlat,
   input  wire logic [3:0]          ctrl,
   output pfr_pkg::pfr_fault_t      chk
);
   logic present;
   logic rsvdOn;
   logic privBad;
   logic writeBad;

   always_comb begin
      present  = xlat.dirPresent & xlat.tblPresent;
      rsvdOn   = ctrl[pfr_pkg::CTL_LARGE] | ctrl[pfr_pkg::CTL_EXT];
      privBad  = xlat.userMode & ~xlat.pageUser;
      // supervisor writes only trip on read-only user pages, and only with protect on
      writeBad = xlat.isWrite & ~xlat.pageWritable &
                 (xlat.userMode | (ctrl[pfr_pkg::CTL_WP] & xlat.pageUser));
      chk.notPresent = ~present;
      chk.rsvdViol   = present & rsvdOn & xlat.rsvdSet;
      chk.protViol   = present & ~chk.rsvdViol & (privBad | writeBad);
      // nothing translates while paging is off
      chk.hit = ctrl[pfr_pkg::CTL_PAGING] &
                (chk.notPresent | chk.rsvdViol | chk.protViol);
   end
endmodule : pfr_fault_check

// ### core/pfr_code_build.sv
`timescale 1ns/1ps
module pfr_code_build (
   input  wire pfr_pkg::pfr_fault_t chk,
   input  wire logic                isWrite,
   input  wire logic                userMode,
   output logic [31:0]              code
);
   always_comb begin
      code = pfr_pkg::WORD_ZERO;
      code[pfr_pkg::EC_PRESENT] = ~chk.notPresent;
      code[pfr_pkg::EC_WRITE]   = isWrite;
      code[pfr_pkg::EC_USER]    = userMode;
      code[pfr_pkg::EC_RESERVED_VIOLATION_BIT]    = chk.rsvdViol;
   end
endmodule : pfr_code_build

// ### core/pfr_core.sv
`timescale 1ns/1ps
module pfr_core (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic                      hreadyout,
   output logic                      hresp,
   output logic [31:0]               hrdata,
   input  wire pfr_pkg::pfr_xlat_t   xlat,
   input  wire pfr_pkg::pfr_ts_step_t tsStep,
   input  wire pfr_pkg::pfr_stack_t  stackInfo,
   input  wire logic                 tssLoaded,
   input  wire logic                 pushAck,
   input  wire logic                 deliverDone,
   output logic                      pushValid,
   output logic [31:0]               pushData,
   output logic [31:0]               faultAddr,
   output logic                      doubleFault,
   output logic                      dirAccSet,
   output logic [31:0]               dirAccAddr,
   output logic                      suppressCommit,
   output logic                      savedAtNewTask,
   output logic                      loadTssAll,
   output logic                      useOldStack
);

   pfr_pkg::pfr_fault_t chk;
   logic [31:0]         code;
   logic                fault;
   logic [3:0]          ctrl_reg, ctrl_next;

   pfr_fault_check u_check (
      .xlat (xlat),
      .ctrl (ctrl_reg),
      .chk  (chk)
   );

   pfr_code_build u_code (
      .chk      (chk),
      .isWrite  (xlat.isWrite),
      .userMode (xlat.userMode),
      .code     (code)
   );

   assign fault = xlat.valid & chk.hit;

   // ---------------- bus slave
   logic        apValid_reg,  apValid_next;
   logic        apWrite_reg,  apWrite_next;
   logic        apHigh_reg,   apHigh_next;
   logic [7:0]  apAddr_reg,   apAddr_next;
   logic [31:0] hrdata_reg,   hrdata_next;
   logic        rdy_reg,      rdy_next;
   logic        resp_reg,     resp_next;
   logic        take;
   logic        wrEn;
   logic        wrFaddr;
   logic        wrStatus;
   logic        wrDone;

   function automatic logic regHit(input logic hi, input logic [7:0] a,
                                   input logic [7:0] off);
      regHit = ~hi & (a == off);
   endfunction : regHit

   pfr_pkg::pfr_state_t state_reg, state_next;
   logic [31:0] faddr_reg,    faddr_next;
   logic [31:0] ecode_reg,    ecode_next;
   logic        dbl_reg,      dbl_next;
   logic        dblPulse_reg, dblPulse_next;
   logic        dirAcc_reg,   dirAcc_next;
   logic [31:0] dirAddr_reg,  dirAddr_next;
   logic        supp_reg,     supp_next;
   logic        newCtx_reg,   newCtx_next;
   logic        oldStk_reg,   oldStk_next;
   logic        pushVal_reg,  pushVal_next;
   logic        loadAll_reg,  loadAll_next;

   function automatic logic [31:0] readMux(input logic hi, input logic [7:0] a);
      readMux = pfr_pkg::WORD_ZERO;
      if (regHit(hi, a, pfr_pkg::OFF_CTRL)) begin
         readMux[3:0] = ctrl_reg;
      end else if (regHit(hi, a, pfr_pkg::OFF_FADDR)) begin
         readMux = faddr_reg;
      end else if (regHit(hi, a, pfr_pkg::OFF_ECODE)) begin
         readMux = ecode_reg;
      end else if (regHit(hi, a, pfr_pkg::OFF_STATUS)) begin
         readMux[pfr_pkg::ST_BUSY]   = (state_reg != pfr_pkg::PF_IDLE);
         readMux[pfr_pkg::ST_DOUBLE] = dbl_reg;
         readMux[pfr_pkg::ST_TSLOAD] = (state_reg == pfr_pkg::PF_TSLOAD);
         readMux[pfr_pkg::ST_NEWCTX] = newCtx_reg;
      end
   endfunction : readMux

   always_comb begin
      take         = hsel & hready & htrans[1];
      apValid_next = take;
      apWrite_next = apWrite_reg;
      apHigh_next  = apHigh_reg;
      apAddr_next  = apAddr_reg;
      hrdata_next  = pfr_pkg::WORD_ZERO;
      rdy_next     = 1'b1;
      resp_next    = 1'b0;
      if (take) begin
         apWrite_next = hwrite;
         apHigh_next  = |haddr[31:8];
         apAddr_next  = haddr[7:0];
         if (!hwrite) begin
            hrdata_next = readMux(|haddr[31:8], haddr[7:0]);
         end
      end
      wrEn     = apValid_reg & apWrite_reg;
      wrFaddr  = wrEn & regHit(apHigh_reg, apAddr_reg, pfr_pkg::OFF_FADDR);
      wrStatus = wrEn & regHit(apHigh_reg, apAddr_reg, pfr_pkg::OFF_STATUS);
      wrDone   = wrEn & regHit(apHigh_reg, apAddr_reg, pfr_pkg::OFF_DONE) &
                 hwdata[pfr_pkg::DONE_BIT];
      ctrl_next = ctrl_reg;
      if (wrEn & regHit(apHigh_reg, apAddr_reg, pfr_pkg::OFF_CTRL)) begin
         ctrl_next = hwdata[3:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         apValid_reg <= 1'b0;
         apWrite_reg <= 1'b0;
         apHigh_reg  <= 1'b0;
         apAddr_reg  <= 8'h00;
         hrdata_reg  <= 32'h0000_0000;
         ctrl_reg    <= pfr_pkg::CTRL_RESET;
         rdy_reg     <= 1'b1;
         resp_reg    <= 1'b0;
      end else begin
         apValid_reg <= apValid_next;
         apWrite_reg <= apWrite_next;
         apHigh_reg  <= apHigh_next;
         apAddr_reg  <= apAddr_next;
         hrdata_reg  <= hrdata_next;
         ctrl_reg    <= ctrl_next;
         rdy_reg     <= rdy_next;
         resp_reg    <= resp_next;
      end
   end

   // zero-wait slave, always OKAY
   // ready flop sits high through reset too, so the bus never stalls
   assign hreadyout = rdy_reg;
   assign hresp     = resp_reg;
   assign hrdata    = hrdata_reg;

   // ---------------- fault reporting
   always_comb begin
      state_next    = state_reg;
      faddr_next    = faddr_reg;
      ecode_next    = ecode_reg;
      dbl_next      = dbl_reg;
      dblPulse_next = 1'b0;
      dirAcc_next   = 1'b0;
      dirAddr_next  = dirAddr_reg;
      supp_next     = 1'b0;
      newCtx_next   = newCtx_reg;
      oldStk_next   = oldStk_reg;
      if (wrFaddr) begin
         faddr_next = hwdata;
      end
      if (wrStatus & hwdata[pfr_pkg::ST_DOUBLE]) begin
         dbl_next = 1'b0;
      end
      case (state_reg)
         pfr_pkg::PF_TSLOAD: begin
            if (tssLoaded) begin
               state_next = pfr_pkg::PF_PUSH;
            end
         end
         pfr_pkg::PF_PUSH: begin
            if (pushAck) begin
               state_next = pfr_pkg::PF_DELIVER;
            end
         end
         pfr_pkg::PF_DELIVER: begin
            if (deliverDone | wrDone) begin
               state_next = pfr_pkg::PF_IDLE;
            end
         end
         default: begin
         end
      endcase
      if (fault) begin
         // the hardware update wins over a software write in the same cycle
         faddr_next = xlat.linAddr;
         ecode_next = code;
         if (chk.protViol) begin
            dirAcc_next  = 1'b1;
            dirAddr_next = xlat.linAddr;
         end
         oldStk_next = stackInfo.stackSplit & stackInfo.samePriv &
                       stackInfo.sameTask;
         if (state_reg != pfr_pkg::PF_IDLE) begin
            // nested fault replaces the address and escalates, sticky set wins
            dbl_next      = 1'b1;
            dblPulse_next = 1'b1;
            state_next    = pfr_pkg::PF_PUSH;
         end else if (tsStep != pfr_pkg::TS_NONE) begin
            newCtx_next = (tsStep == pfr_pkg::TS_READ_SEG) |
                          (tsStep == pfr_pkg::TS_READ_LDT);
            state_next  = pfr_pkg::PF_TSLOAD;
         end else begin
            newCtx_next = 1'b0;
            supp_next   = 1'b1;
            state_next  = pfr_pkg::PF_PUSH;
         end
      end
      // outputs leave from flops, decoded one cycle early from the next state
      pushVal_next = (state_next == pfr_pkg::PF_PUSH);
      loadAll_next = (state_next == pfr_pkg::PF_TSLOAD);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg    <= pfr_pkg::PF_IDLE;
         faddr_reg    <= 32'h0000_0000;
         ecode_reg    <= 32'h0000_0000;
         dbl_reg      <= 1'b0;
         dblPulse_reg <= 1'b0;
         dirAcc_reg   <= 1'b0;
         dirAddr_reg  <= 32'h0000_0000;
         supp_reg     <= 1'b0;
         newCtx_reg   <= 1'b0;
         oldStk_reg   <= 1'b0;
         pushVal_reg  <= 1'b0;
         loadAll_reg  <= 1'b0;
      end else begin
         state_reg    <= state_next;
         faddr_reg    <= faddr_next;
         ecode_reg    <= ecode_next;
         dbl_reg      <= dbl_next;
         dblPulse_reg <= dblPulse_next;
         dirAcc_reg   <= dirAcc_next;
         dirAddr_reg  <= dirAddr_next;
         supp_reg     <= supp_next;
         newCtx_reg   <= newCtx_next;
         oldStk_reg   <= oldStk_next;
         pushVal_reg  <= pushVal_next;
         loadAll_reg  <= loadAll_next;
      end
   end

   assign pushValid      = pushVal_reg;
   assign pushData       = ecode_reg;
   assign faultAddr      = faddr_reg;
   assign doubleFault    = dblPulse_reg;
   assign dirAccSet      = dirAcc_reg;
   assign dirAccAddr     = dirAddr_reg;
   assign suppressCommit = supp_reg;
   assign savedAtNewTask = newCtx_reg;
   assign loadTssAll     = loadAll_reg;
   assign useOldStack    = oldStk_reg;

   // ---------------- checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   logic idleNow;
   assign idleNow = (state_reg == pfr_pkg::PF_IDLE);

   sequence s_tsEnter;
      fault && idleNow && (tsStep != pfr_pkg::TS_NONE);
   endsequence

   sequence s_loading;
      loadTssAll && !pushValid;
   endsequence

   sequence s_plainEnter;
      fault && idleNow && (tsStep == pfr_pkg::TS_NONE);
   endsequence

   fault_addr_a: assert property (fault |=> faultAddr == $past(xlat.linAddr))
      else $error("fault address not loaded");

   nested_over_a: assert property (fault && !idleNow |=>
      doubleFault && faultAddr == $past(xlat.linAddr) && pushValid)
      else $error("nested fault did not overwrite address");

   plain_push_a: assert property (s_plainEnter |=> pushValid && suppressCommit &&
      pushData[pfr_pkg::EC_WRITE] == $past(xlat.isWrite) &&
      pushData[pfr_pkg::EC_USER] == $past(xlat.userMode) && !savedAtNewTask)
      else $error("plain fault push wrong");

   present_bit_a: assert property (fault |=>
      pushData[pfr_pkg::EC_PRESENT] == !$past(chk.notPresent) && pushData[31:4] == 28'h0000000)
      else $error("present bit or upper bits wrong");

   reserved_violation_bit_gate_a: assert property (fault && !ctrl_reg[pfr_pkg::CTL_LARGE] &&
      !ctrl_reg[pfr_pkg::CTL_EXT] |=> !pushData[pfr_pkg::EC_RESERVED_VIOLATION_BIT])
      else $error("reserved flag without large or extended paging");

   paging_off_a: assert property (!ctrl_reg[pfr_pkg::CTL_PAGING] |-> !chk.hit)
      else $error("fault raised with paging off");

   wp_fault_a: assert property (xlat.dirPresent && xlat.tblPresent && !xlat.rsvdSet &&
      ctrl_reg[pfr_pkg::CTL_PAGING] && ctrl_reg[pfr_pkg::CTL_WP] && !xlat.userMode &&
      xlat.isWrite && !xlat.pageWritable && xlat.pageUser |-> chk.hit && chk.protViol)
      else $error("supervisor write to read-only user page not faulted");

   dir_acc_a: assert property (fault && chk.protViol |=>
      dirAccSet && dirAccAddr == $past(xlat.linAddr))
      else $error("directory accessed flag not set");

   ts_load_a: assert property (s_tsEnter |=> s_loading ##0
      (savedAtNewTask == ($past(tsStep) == pfr_pkg::TS_READ_SEG ||
                          $past(tsStep) == pfr_pkg::TS_READ_LDT)))
      else $error("task switch fault raised before state load");

   ts_raise_a: assert property (loadTssAll && tssLoaded && !fault |=> pushValid)
      else $error("exception not raised after state load");

   stack_pair_a: assert property (fault |=> useOldStack ==
      &$past(stackInfo))
      else $error("inconsistent stack choice wrong");

   push_hold_a: assert property (pushValid && !pushAck && !fault |=>
      pushValid && $stable(pushData))
      else $error("error code not held while waiting");

   dbl_sticky_a: assert property (dbl_reg && !wrStatus |=> dbl_reg)
      else $error("double fault flag dropped");

   deliver_end_a: assert property (state_reg == pfr_pkg::PF_DELIVER &&
      (deliverDone || wrDone) && !fault |=> idleNow)
      else $error("delivery did not end");

   plain_only_a: assert property (suppressCommit |-> pushValid && !loadTssAll)
      else $error("commit suppressed outside plain fault");

   nested_push_a: assert property (fault && !idleNow |=> !loadTssAll)
      else $error("nested fault waited on task state");

endmodule : pfr_core

// ### tb/pfr_handler_model.sv
`timescale 1ns/1ps
module pfr_handler_model (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [3:0]  slowCycles,
   input  wire logic        pushValid,
   input  wire logic        loadTssAll,
   input  wire logic [31:0] faultAddr,
   output logic             pushAck,
   output logic             deliverDone,
   output logic             tssLoaded,
   output logic [31:0]      savedAddr
);
   logic [3:0] waitCnt;
   logic       inHandler;

   // slow answers let a nested fault land while the first is still in flight
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {pushAck, deliverDone, tssLoaded, inHandler} <= 4'h0;
         waitCnt   <= 4'h0;
         savedAddr <= 32'h0000_0000;
      end else begin
         pushAck     <= 1'b0;
         deliverDone <= 1'b0;
         tssLoaded   <= 1'b0;
         if (!(pushValid | loadTssAll | inHandler)) begin
            waitCnt <= 4'h0;
         end else if (waitCnt < slowCycles) begin
            waitCnt <= waitCnt + 4'h1;
         end else begin
            waitCnt <= 4'h0;
            if (loadTssAll) begin
               tssLoaded <= !tssLoaded;
            end else if (pushValid) begin
               pushAck   <= !pushAck;
               inHandler <= 1'b1;
               savedAddr <= faultAddr;
            end else begin
               deliverDone <= 1'b1;
               inHandler   <= 1'b0;
            end
         end
      end
   end
endmodule : pfr_handler_model

// ### tb/page_fault_reporting_tb_top.sv
`timescale 1ns/1ps
module page_fault_reporting_tb_top;
   logic                  clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0]           haddr, hwdata, hrdata, rd, prev;
   logic [1:0]            htrans;
   logic [2:0]            hsize;
   pfr_pkg::pfr_xlat_t    xlat, x;
   pfr_pkg::pfr_ts_step_t tsStep;
   pfr_pkg::pfr_stack_t   stackInfo;
   logic                  tssLoaded, pushAck, deliverDone, pushValid, doubleFault;
   logic                  dirAccSet, suppressCommit, savedAtNewTask, loadTssAll, useOldStack;
   logic [31:0]           pushData, faultAddr, dirAccAddr, savedAddr, r1, r2;
   logic [3:0]            slowCycles, c;
   logic [5:0]            e;
   logic                  stackLoadOnce;
   int                    nErrors, checkCount, cycles, seed;

   assign hready = hreadyout;

   pfr_core          u_pfr_core (.*);
   pfr_handler_model u_pfr_handler_model (.*);

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic finishTest;
      $display("checks %0d errors %0d", checkCount, nErrors);
      if (nErrors == 0 && checkCount > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : finishTest

   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         nErrors++;
         finishTest();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checkCount++;
      if (got !== exp) begin
         nErrors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // the error code must not be offered before the new task state is in
   always @(posedge clk) if (loadTssAll === 1'b1) chk(pushValid, 1'b0);

   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : ahb

   task automatic fault(input pfr_pkg::pfr_xlat_t f, input pfr_pkg::pfr_ts_step_t t);
      @(posedge clk);
      xlat      <= f;
      tsStep    <= t;
      // software that loads the stack in one step never leaves a split pair
      stackInfo <= 3'($random(seed)) & {!stackLoadOnce, 2'b11};
      @(posedge clk);
      xlat   <= '0;
      tsStep <= pfr_pkg::TS_NONE;
      #1;
   endtask : fault

   task automatic waitIdle;
      for (int i = 0; i < 40; i++) begin
         ahb(1'b0, 32'(pfr_pkg::OFF_STATUS), 32'h0);
         if (rd[pfr_pkg::ST_BUSY] === 1'b0) break;
      end
      chk(rd[pfr_pkg::ST_BUSY], 1'b0);
   endtask : waitIdle

   // {hit, protection only, code[3:0]}
   function automatic logic [5:0] expectFault(input pfr_pkg::pfr_xlat_t f,
                                              input logic [3:0] k);
      logic pres, rsv, prot;
      pres = f.dirPresent & f.tblPresent;
      rsv  = pres & f.rsvdSet & (k[1] | k[2]);
      prot = pres & ((f.userMode & !f.pageUser) | (f.isWrite & !f.pageWritable
             & (f.userMode | (k[3] & f.pageUser))));
      return {k[0] & (!pres | rsv | prot), prot & !rsv, rsv, f.userMode, f.isWrite, pres};
   endfunction : expectFault

   initial begin
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize      = 3'h2;
      xlat       = '0;
      tsStep     = pfr_pkg::TS_NONE;
      stackInfo  = '0;
      stackLoadOnce = 1'b0;
      slowCycles = 4'h0;
      seed       = 98798;
      rst_n      = 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      ahb(1'b0, 32'(pfr_pkg::OFF_CTRL), 32'h0);
      chk(rd, 32'h0);
      ahb(1'b1, 32'h0000_0104, 32'hFFFF_FFFF);
      ahb(1'b0, 32'h0000_0104, 32'h0);
      chk(rd, 32'h0);
      for (int n = 0; n < 48; n++) begin
         r1 = $random(seed);
         r2 = $random(seed);
         x  = {1'b1, r1, r2[6:0]};
         x.dirPresent |= r2[8];
         x.tblPresent |= r2[9];
         c = {r2[13:11], r2[10] | r2[14]};
         slowCycles <= {2'h0, r2[17:16]};
         ahb(1'b1, 32'(pfr_pkg::OFF_CTRL), {28'h0, c});
         e    = expectFault(x, c);
         prev = faultAddr;
         fault(x, pfr_pkg::TS_NONE);
         chk(pushValid, e[5]);
         chk(faultAddr, e[5] ? x.linAddr : prev);
         chk(suppressCommit, e[5]);
         if (e[5]) begin
            chk(pushData, {28'h0, e[3:0]});
            chk(useOldStack, &stackInfo);
            chk(doubleFault, 1'b0);
            if (!e[3]) chk(dirAccSet, e[4]);
            if (e[4]) chk(dirAccAddr, x.linAddr);
            waitIdle();
            ahb(1'b0, 32'(pfr_pkg::OFF_ECODE), 32'h0);
            chk(rd, {28'h0, e[3:0]});
            ahb(1'b0, 32'(pfr_pkg::OFF_FADDR), 32'h0);
            chk(rd, x.linAddr);
            chk(savedAddr, x.linAddr);
         end
      end
      ahb(1'b1, 32'(pfr_pkg::OFF_CTRL), 32'h1);
      slowCycles <= 4'h3;
      for (int s = 1; s < 6; s++) begin
         x         = '0;
         x.valid   = 1'b1;
         x.linAddr = 32'h0040_0000 + 32'(s);
         fault(x, pfr_pkg::pfr_ts_step_t'(s));
         chk(loadTssAll, 1'b1);
         chk(savedAtNewTask, s > 3);
         chk(suppressCommit, 1'b0);
         waitIdle();
         chk(faultAddr, x.linAddr);
      end
      // long answers keep the first fault in flight under the later ones
      slowCycles <= 4'hF;
      stackLoadOnce = 1'b1;
      for (int k = 0; k < 3; k++) begin
         x.linAddr = 32'hA000_0000 + 32'(k * 4096);
         x.isWrite = k[0];
         fault(x, pfr_pkg::TS_NONE);
         chk(faultAddr, x.linAddr);
         chk(doubleFault, k != 0);
         chk(pushData, {30'h0, k[0], 1'b0});
         chk(useOldStack, 1'b0);
      end
      ahb(1'b0, 32'(pfr_pkg::OFF_STATUS), 32'h0);
      chk(rd[pfr_pkg::ST_DOUBLE], 1'b1);
      ahb(1'b1, 32'(pfr_pkg::OFF_STATUS), 32'h2);
      ahb(1'b0, 32'(pfr_pkg::OFF_STATUS), 32'h0);
      chk(rd[pfr_pkg::ST_DOUBLE], 1'b0);
      waitIdle();
      chk(savedAddr, 32'hA000_2000);
      // software ends delivery well before the slow handler would
      fault(x, pfr_pkg::TS_NONE);
      while (pushValid !== 1'b0) @(posedge clk);
      ahb(1'b0, 32'(pfr_pkg::OFF_STATUS), 32'h0);
      chk(rd[pfr_pkg::ST_BUSY], 1'b1);
      ahb(1'b1, 32'(pfr_pkg::OFF_DONE), 32'h1);
      ahb(1'b0, 32'(pfr_pkg::OFF_STATUS), 32'h0);
      chk(rd[pfr_pkg::ST_BUSY], 1'b0);
      finishTest();
   end
endmodule : page_fault_reporting_tb_top
